// ==== hdl/hpcg_defs.svh ====
// constants for the packet id and checksum gate link
`ifndef HPCG_DEFS_SVH
`define HPCG_DEFS_SVH
`define HPCG_PKT_W        32
`define HPCG_INFO_W       24
`define HPCG_ID_MSB       31
`define HPCG_ID_LSB       24
`define HPCG_ID_CHECKSUM  8'h00
`define HPCG_ID_CONFIG    8'h01
`define HPCG_ID_CONTROL   8'h02
`define HPCG_ID_ALLFRAME  8'h03
`define HPCG_ID_RXLINE    8'h0f
`define HPCG_ID_RXC_LO    8'h10
`define HPCG_ID_RXC_HI    8'h1b
`define HPCG_ID_SPEC_LO   8'h1c
`define HPCG_ID_SPEC_HI   8'h1f
`define HPCG_ID_FRAME_LO  8'h20
`define HPCG_ID_FRAME_HI  8'h27
`define HPCG_ID_UADDR_EN  8'h78
`define HPCG_ID_UADDR_LO  8'h80
`define HPCG_ID_UADDR_HI  8'h8f
`define HPCG_OID_BIW      8'h00
`define HPCG_OID_ADDR     8'h01
`define HPCG_OID_VEC_LO   8'h02
`define HPCG_OID_VEC_HI   8'h57
`define HPCG_OID_STATUS   8'h7f
`define HPCG_OID_PARTID   8'hff
`define HPCG_PART_ID      24'h5a3c96
`define HPCG_BITCNT_W     6
`define HPCG_SCK_HALF     4'h3
`define HPCG_SCK_DIV_W    4
`endif

// ==== hdl/hpcg_pkg.sv ====
// types shared by both ends of the packet link
package hpcg_pkg;
    typedef enum logic [4:0] {
        HPCG_K_CHECKSUM = 5'h00,
        HPCG_K_CONFIG   = 5'h01,
        HPCG_K_CONTROL  = 5'h02,
        HPCG_K_ALLFRAME = 5'h03,
        HPCG_K_RXLINE   = 5'h04,
        HPCG_K_RXCTRL   = 5'h05,
        HPCG_K_SPECIAL  = 5'h06,
        HPCG_K_FRAME    = 5'h07,
        HPCG_K_UADDR_EN = 5'h08,
        HPCG_K_UADDR    = 5'h09,
        HPCG_K_RESERVED = 5'h0a
    } hpcg_kind_t;
    typedef logic [31:0] hpcg_pkt_t;
endpackage

// ==== hdl/hpcg_link_if.sv ====
// spi link between host master and decoder device
`timescale 1ns/1ps
interface hpcg_link_if;
    logic sck;        // serial clock, host driven
    logic ss_n;       // select, active low, host driven
    logic mosi;       // host to device data
    logic miso;       // device to host data
    logic ready_n;    // device ready, active low
    modport host (output sck, output ss_n, output mosi, input miso, input ready_n);
    modport dev  (input sck, input ss_n, input mosi, output miso, output ready_n);
endinterface

// ==== hdl/hpcg_device.sv ====
// decoder end: packet receiver, id classifier, checksum gate, packet sender
`timescale 1ns/1ps
`include "hpcg_defs.svh"
// Function
// - classify packets by top eight id bits
// - decode checksum, config, control, allframe, rxline ids
// - ids 10-1b select receiver control step
// - ids 1c-1f leave checksum, gate and rx_valid_o unchanged
// - ids 20-27 assign frame groups, reversed
// - 78 user address enable, 80-8f addresses
// - host never sends reserved ids
// - outgoing packets use documented id set
// - packets shift msb first, bit 31 first
// - xor info bits into checksum register
// - reset disables and loads part id checksum
// - accepted non-checksum packet outside ids 1c-1f disables delivery
// - matching checksum packet re-enables delivery
// - disabled: only part id sent, ready asserted
// - disabled state blocks only outgoing data
// - idle host sends zero checksum packet; hpcg_host sends nothing and keeps select high while idle
// - checksum packet: id zero, value low 24
// - full duplex 32 bit transfers
// - packet starts only after select falling edge
module hpcg_device (
    input  wire logic               sys_clk_i,
    input  wire logic               srst_i,
    hpcg_link_if.dev                link,
    input  wire hpcg_pkg::hpcg_pkt_t tx_pkt_i,
    input  wire logic               tx_valid_i,
    output logic                    tx_ready_o,
    output hpcg_pkg::hpcg_pkt_t     rx_pkt_o,
    output hpcg_pkg::hpcg_kind_t    rx_kind_o,
    output logic [3:0]              rx_index_o,
    output logic                    rx_valid_o,
    output logic                    enabled_o,
    output logic                    cksum_ok_o,
    output logic                    cksum_bad_o
);
    import hpcg_pkg::*;

    // classify a host packet id into its kind
    function automatic hpcg_kind_t classify(input logic [7:0] id);
        if (id == `HPCG_ID_CHECKSUM)                             classify = HPCG_K_CHECKSUM;
        else if (id == `HPCG_ID_CONFIG)                          classify = HPCG_K_CONFIG;
        else if (id == `HPCG_ID_CONTROL)                         classify = HPCG_K_CONTROL;
        else if (id == `HPCG_ID_ALLFRAME)                        classify = HPCG_K_ALLFRAME;
        else if (id == `HPCG_ID_RXLINE)                          classify = HPCG_K_RXLINE;
        else if (id >= `HPCG_ID_RXC_LO && id <= `HPCG_ID_RXC_HI)   classify = HPCG_K_RXCTRL;
        else if (id >= `HPCG_ID_SPEC_LO && id <= `HPCG_ID_SPEC_HI) classify = HPCG_K_SPECIAL;
        else if (id >= `HPCG_ID_FRAME_LO && id <= `HPCG_ID_FRAME_HI) classify = HPCG_K_FRAME;
        else if (id == `HPCG_ID_UADDR_EN)                        classify = HPCG_K_UADDR_EN;
        else if (id >= `HPCG_ID_UADDR_LO && id <= `HPCG_ID_UADDR_HI) classify = HPCG_K_UADDR;
        else                                                     classify = HPCG_K_RESERVED;
    endfunction

    // index within a ranged id group
    function automatic logic [3:0] id_index(input logic [7:0] id);
        if (id >= `HPCG_ID_FRAME_LO && id <= `HPCG_ID_FRAME_HI)
            id_index = 4'(`HPCG_ID_FRAME_HI - id);          // 0 -> frames 0-15
        else if (id >= `HPCG_ID_RXC_LO && id <= `HPCG_ID_RXC_HI)
            id_index = 4'(id - `HPCG_ID_RXC_LO);
        else if (id >= `HPCG_ID_UADDR_LO && id <= `HPCG_ID_UADDR_HI)
            id_index = 4'(id - `HPCG_ID_UADDR_LO);
        else
            id_index = 4'h0;
    endfunction

    // true when an outgoing id is in the allowed set
    function automatic logic out_id_ok(input logic [7:0] id);
        out_id_ok = (id == `HPCG_OID_BIW) || (id == `HPCG_OID_ADDR) ||
                    (id >= `HPCG_OID_VEC_LO && id <= `HPCG_OID_VEC_HI) ||
                    (id == `HPCG_OID_STATUS) || (id == `HPCG_OID_PARTID);
    endfunction

    logic [2:0] sck_sync_reg;  // [0] first stage, [1] second, [2] history
    logic [2:0] ss_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic       sck_rise;
    logic       sck_fall;
    logic       ss_fall;
    logic       ss_low;

    // two-flop synchronisers, edges found behind second stage
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sck_sync_reg  <= 3'h0;
            ss_sync_reg   <= 3'h7;
            mosi_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg  <= {sck_sync_reg[1:0], link.sck};
            ss_sync_reg   <= {ss_sync_reg[1:0], link.ss_n};
            mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
        end
    end
    assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
    assign ss_fall  = ~ss_sync_reg[1] & ss_sync_reg[2];
    assign ss_low   = ~ss_sync_reg[1];

    logic                       armed_reg;    // select edge seen for this packet
    logic [`HPCG_BITCNT_W-1:0]  bitcnt_reg;
    logic [31:0]                shin_reg;
    logic [31:0]                shout_reg;
    logic                       done;
    logic [31:0]                rx_word;

    // a full packet ends on the 32nd sampling edge
    assign done    = armed_reg && ss_low && sck_rise &&
                     (bitcnt_reg == `HPCG_BITCNT_W'(`HPCG_PKT_W - 1));
    assign rx_word = {shin_reg[30:0], mosi_sync_reg[1]};

    // bit counter and arming; deselect drops a partial packet
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            armed_reg  <= 1'b0;
            bitcnt_reg <= '0;
        end else if (ss_fall) begin
            armed_reg  <= 1'b1;
            bitcnt_reg <= '0;
        end else if (!ss_low) begin
            armed_reg  <= 1'b0;
            bitcnt_reg <= '0;
        end else if (done) begin
            bitcnt_reg <= '0;   // back-to-back packets within one select
        end else if (armed_reg && sck_rise) begin
            bitcnt_reg <= bitcnt_reg + `HPCG_BITCNT_W'(1);
        end
    end

    // receive shifter, msb first
    always_ff @(posedge sys_clk_i) begin
        if (srst_i)
            shin_reg <= '0;
        else if (armed_reg && ss_low && sck_rise)
            shin_reg <= rx_word;
    end

    logic [23:0] cksum_reg;
    logic        enabled_reg;
    hpcg_kind_t  kind;
    assign kind = classify(rx_word[`HPCG_ID_MSB:`HPCG_ID_LSB]);

    // checksum register and delivery gate
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cksum_reg   <= `HPCG_PART_ID;
            enabled_reg <= 1'b0;
        end else if (done) begin
            if (kind == HPCG_K_CHECKSUM) begin
                if (rx_word[`HPCG_INFO_W-1:0] == cksum_reg)
                    enabled_reg <= 1'b1;
            end else if (kind != HPCG_K_SPECIAL) begin
                cksum_reg   <= cksum_reg ^ rx_word[`HPCG_INFO_W-1:0];
                enabled_reg <= 1'b0;
            end
        end
    end

    // decoded packet output, delivered regardless of gate
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rx_pkt_o    <= '0;
            rx_kind_o   <= HPCG_K_CHECKSUM;
            rx_index_o  <= 4'h0;
            rx_valid_o  <= 1'b0;
            cksum_ok_o  <= 1'b0;
            cksum_bad_o <= 1'b0;
        end else begin
            rx_valid_o  <= done && kind != HPCG_K_SPECIAL;
            cksum_ok_o  <= done && kind == HPCG_K_CHECKSUM &&
                           rx_word[`HPCG_INFO_W-1:0] == cksum_reg;
            cksum_bad_o <= done && kind == HPCG_K_CHECKSUM &&
                           rx_word[`HPCG_INFO_W-1:0] != cksum_reg;
            if (done) begin
                rx_pkt_o   <= rx_word;
                rx_kind_o  <= kind;
                rx_index_o <= id_index(rx_word[`HPCG_ID_MSB:`HPCG_ID_LSB]);
            end
        end
    end

    logic        pend_reg;    // a user packet loaded for sending
    logic        take;
    hpcg_pkt_t   next_out;
    assign take = tx_valid_i && !pend_reg && enabled_reg && out_id_ok(tx_pkt_i[31:24]);
    // next word to shift: user packet when enabled and one is pending, else part id
    assign next_out = (enabled_reg && pend_reg) ? shout_reg :
                      {`HPCG_OID_PARTID, `HPCG_PART_ID};

    logic [31:0] txbuf_reg;
    // hold one outgoing packet until a transfer carries it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pend_reg   <= 1'b0;
            shout_reg  <= '0;
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= !pend_reg && !take && enabled_reg;
            if (take) begin
                pend_reg  <= 1'b1;
                shout_reg <= tx_pkt_i;
            end else if (done && enabled_reg) begin
                pend_reg  <= 1'b0;
            end
        end
    end

    // transmit shifter: loads at packet start, shifts on sck fall
    always_ff @(posedge sys_clk_i) begin
        if (srst_i)
            txbuf_reg <= {`HPCG_OID_PARTID, `HPCG_PART_ID};
        else if (ss_fall || done)
            txbuf_reg <= next_out;
        else if (armed_reg && ss_low && sck_fall && bitcnt_reg != '0)
            txbuf_reg <= {txbuf_reg[30:0], 1'b0};
    end

    // miso and ready pins; ready low while selected, when something to read, or when gated
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            link.miso    <= 1'b0;
            link.ready_n <= 1'b1;
            enabled_o    <= 1'b0;
        end else begin
            link.miso    <= ss_fall ? next_out[31] : txbuf_reg[31];  // holds through sck high
            link.ready_n <= !(ss_low || !enabled_reg || pend_reg);
            enabled_o    <= enabled_reg;
        end
    end
endmodule

// ==== hdl/hpcg_host.sv ====
// host end: spi master that sends one packet per request
`timescale 1ns/1ps
`include "hpcg_defs.svh"
module hpcg_host (
    input  wire logic                sys_clk_i,
    input  wire logic                srst_i,
    hpcg_link_if.host                link,
    input  wire hpcg_pkg::hpcg_pkt_t cmd_pkt_i,
    input  wire logic                cmd_valid_i,
    output logic                     cmd_ready_o,
    output hpcg_pkg::hpcg_pkt_t      rsp_pkt_o,
    output logic                     rsp_valid_o,
    output logic                     dev_ready_o
);
    import hpcg_pkg::*;

    typedef enum logic [1:0] {
        HPCG_H_IDLE = 2'b00,
        HPCG_H_WAIT = 2'b01,
        HPCG_H_SHIFT = 2'b10,
        HPCG_H_END  = 2'b11
    } hpcg_hstate_t;

    hpcg_hstate_t              state_reg;
    logic [`HPCG_SCK_DIV_W-1:0] div_reg;
    logic [`HPCG_BITCNT_W-1:0]  bit_reg;
    logic [31:0]               out_reg;
    logic [31:0]               in_reg;
    logic [1:0]                miso_sync_reg;
    logic [1:0]                rdy_sync_reg;
    logic                      tick;

    // pin synchronisers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            miso_sync_reg <= 2'h0;
            rdy_sync_reg  <= 2'h3;
        end else begin
            miso_sync_reg <= {miso_sync_reg[0], link.miso};
            rdy_sync_reg  <= {rdy_sync_reg[0], link.ready_n};
        end
    end

    // half-period enable divider for sck
    assign tick = (div_reg == `HPCG_SCK_HALF);
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || tick || state_reg != HPCG_H_SHIFT)
            div_reg <= '0;
        else
            div_reg <= div_reg + `HPCG_SCK_DIV_W'(1);
    end

    // master sequence: select, await ready, shift 32 bits, deselect
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg   <= HPCG_H_IDLE;
            link.ss_n   <= 1'b1;
            link.sck    <= 1'b0;
            link.mosi   <= 1'b0;
            bit_reg     <= '0;
            out_reg     <= '0;
            in_reg      <= '0;
            cmd_ready_o <= 1'b0;
            rsp_pkt_o   <= '0;
            rsp_valid_o <= 1'b0;
            dev_ready_o <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            dev_ready_o <= ~rdy_sync_reg[1];
            cmd_ready_o <= (state_reg == HPCG_H_IDLE) && !cmd_valid_i;
            case (state_reg)
                HPCG_H_IDLE: begin
                    if (cmd_valid_i && cmd_ready_o) begin
                        out_reg   <= cmd_pkt_i;
                        link.ss_n <= 1'b0;   // falling edge opens each packet
                        state_reg <= HPCG_H_WAIT;
                    end
                end
                HPCG_H_WAIT: begin
                    if (!rdy_sync_reg[1]) begin
                        link.mosi <= out_reg[31];
                        bit_reg   <= '0;
                        state_reg <= HPCG_H_SHIFT;
                    end
                end
                HPCG_H_SHIFT: begin
                    if (tick) begin
                        link.sck <= ~link.sck;
                        if (link.sck) begin
                            // sample on the fall: the device moves miso some clocks after each
                            // fall, and the synced level has settled by the next fall
                            in_reg    <= {in_reg[30:0], miso_sync_reg[1]};
                            out_reg   <= {out_reg[30:0], 1'b0};
                            link.mosi <= out_reg[30];
                            if (bit_reg == `HPCG_BITCNT_W'(`HPCG_PKT_W - 1))
                                state_reg <= HPCG_H_END;
                            bit_reg <= bit_reg + `HPCG_BITCNT_W'(1);
                        end
                    end
                end
                HPCG_H_END: begin
                    link.ss_n   <= 1'b1;
                    rsp_pkt_o   <= in_reg;
                    rsp_valid_o <= 1'b1;
                    state_reg   <= HPCG_H_IDLE;
                end
                default: state_reg <= HPCG_H_IDLE;
            endcase
        end
    end
endmodule

// ==== bench/hpcg_link_properties.sv ====
// link timing assertions for the packet id and checksum gate
`timescale 1ns/1ps
module hpcg_link_properties (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic ready_n
);
    logic [4:0] rise_cnt_reg;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // sck rises within one select, modulo one packet
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || ss_n) rise_cnt_reg <= 5'h00;
        else if ($rose(sck)) rise_cnt_reg <= rise_cnt_reg + 5'h01;
    end
    property p_sck_sel; $rose(sck) |-> !ss_n; endproperty
    a_sck_sel: assert property (p_sck_sel) else $error("sck rose while deselected");
    property p_sel_fall; $fell(ss_n) |-> !sck; endproperty
    a_sel_fall: assert property (p_sel_fall) else $error("select fell with sck high");
    property p_rdy_rst; $fell(srst_i) |-> ##[0:2] !ready_n; endproperty
    a_rdy_rst: assert property (p_rdy_rst) else $error("ready not asserted after reset");
    property p_sck_high; $rose(sck) |-> sck [*4]; endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high phase short");
    property p_sck_low; $fell(sck) |-> !sck [*4]; endproperty
    a_sck_low: assert property (p_sck_low) else $error("sck low phase short");
    property p_mosi_hold; sck && $past(sck) |-> $stable(mosi); endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved in sck high");
    property p_miso_hold; sck && $past(sck) |-> $stable(miso); endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved in sck high");
    property p_whole; $rose(ss_n) |-> rise_cnt_reg == 5'h00; endproperty
    a_whole: assert property (p_whole) else $error("select ended mid packet");
    c_frame: cover property ($rose(sck) && rise_cnt_reg == 5'h1f);
    c_desel: cover property ($rose(ss_n));
    c_ready: cover property ($rose(ready_n));
endmodule

// ==== bench/host_packet_id_checksum_gate_tb.sv ====
// bench for host and device ends joined over the packet link
`timescale 1ns/1ps
`include "hpcg_defs.svh"
module host_packet_id_checksum_gate_tb;
    import hpcg_pkg::*;
    logic clk, rst, cmd_valid, tx_valid, cmd_ready, rsp_valid, dev_ready, tx_ready;
    logic rx_valid, enabled, ok, bad, rx_valid_b;
    hpcg_pkt_t cmd_pkt, tx_pkt, rsp_pkt, rx_pkt, rx_pkt_b;
    hpcg_kind_t rx_kind;
    logic [3:0] rx_index;
    logic [23:0] cs;
    int num_errors, checks, rx_cnt, rx_cnt_b, ok_cnt, bad_cnt;
    hpcg_link_if lk();
    hpcg_link_if lk2();
    hpcg_host i_hpcg_host (.sys_clk_i(clk), .srst_i(rst), .link(lk), .cmd_pkt_i(cmd_pkt),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .rsp_pkt_o(rsp_pkt),
        .rsp_valid_o(rsp_valid), .dev_ready_o(dev_ready));
    hpcg_device i_hpcg_device (.sys_clk_i(clk), .srst_i(rst), .link(lk), .tx_pkt_i(tx_pkt),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_pkt_o(rx_pkt), .rx_kind_o(rx_kind),
        .rx_index_o(rx_index), .rx_valid_o(rx_valid), .enabled_o(enabled),
        .cksum_ok_o(ok), .cksum_bad_o(bad));
    // second device fed by a bench driver that breaks framing on purpose
    hpcg_device i_hpcg_device_b (.sys_clk_i(clk), .srst_i(rst), .link(lk2),
        .tx_pkt_i(32'h0), .tx_valid_i(1'b0), .tx_ready_o(), .rx_pkt_o(rx_pkt_b),
        .rx_kind_o(), .rx_index_o(), .rx_valid_o(rx_valid_b), .enabled_o(),
        .cksum_ok_o(), .cksum_bad_o());
    hpcg_link_properties i_hpcg_link_properties (.sys_clk_i(clk), .srst_i(rst),
        .sck(lk.sck), .ss_n(lk.ss_n), .mosi(lk.mosi), .miso(lk.miso), .ready_n(lk.ready_n));
    // clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulse counters
    always @(posedge clk) begin
        if (rx_valid === 1'b1) rx_cnt++;
        if (rx_valid_b === 1'b1) rx_cnt_b++;
        if (ok === 1'b1) ok_cnt++;
        if (bad === 1'b1) bad_cnt++;
    end
    task automatic wrap_up();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_pkt(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_pkt({31'h0, got}, {31'h0, exp});
    endtask
    // one host transfer, returns once the device has decoded it
    task automatic xfer(input hpcg_pkt_t p);
        int n;
        n = 0;
        @(posedge clk);
        cmd_pkt <= p;
        cmd_valid <= 1'b1;
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (n >= 600) num_errors++;
        repeat (10) @(negedge clk);
    endtask
    function automatic hpcg_kind_t kind_of(input logic [7:0] id, output logic [3:0] x);
        x = 4'h0;
        case (id) inside
            8'h01: return HPCG_K_CONFIG;
            8'h02: return HPCG_K_CONTROL;
            8'h03: return HPCG_K_ALLFRAME;
            8'h0f: return HPCG_K_RXLINE;
            [8'h10:8'h1b]: begin x = id[3:0]; return HPCG_K_RXCTRL; end
            [8'h1c:8'h1f]: return HPCG_K_SPECIAL;
            [8'h20:8'h27]: begin x = {1'b0, ~id[2:0]}; return HPCG_K_FRAME; end
            8'h78: return HPCG_K_UADDR_EN;
            [8'h80:8'h8f]: begin x = id[3:0]; return HPCG_K_UADDR; end
            default: return HPCG_K_RESERVED;
        endcase
    endfunction
    task automatic t_locked();
        cmp_bit(enabled, 1'b0);
        cmp_bit(dev_ready, 1'b1);
        cmp_bit(tx_ready, 1'b0);
        xfer(32'h0);
        cmp_pkt(rsp_pkt, {`HPCG_OID_PARTID, `HPCG_PART_ID});
        cmp_pkt(32'(bad_cnt), 32'h1);
        xfer({8'h00, cs});
        cmp_pkt(32'(ok_cnt), 32'h1);
        cmp_bit(enabled, 1'b1);
        $display("test locked done");
    endtask
    task automatic t_decode();
        logic [7:0] id;
        logic [3:0] x;
        logic [23:0] d;
        hpcg_kind_t k;
        for (int i = 1; i < 144; i++) begin
            id = i[7:0];
            k = kind_of(id, x);
            if (k != HPCG_K_RESERVED && k != HPCG_K_SPECIAL) begin
                d = {~id, id, 8'h5a};
                xfer({id, d});
                cs = cs ^ d;
                cmp_pkt(rx_pkt, {id, d});
                cmp_pkt({27'h0, rx_kind}, {27'h0, k});
                if (k inside {HPCG_K_RXCTRL, HPCG_K_FRAME, HPCG_K_UADDR})
                    cmp_pkt({28'h0, rx_index}, {28'h0, x});
                cmp_bit(enabled, 1'b0);
                if (i > 1) cmp_pkt(rsp_pkt, {`HPCG_OID_PARTID, `HPCG_PART_ID});
            end
        end
        xfer({8'h00, cs});
        cmp_bit(enabled, 1'b1);
        $display("test decode done");
    endtask
    task automatic t_special();
        int n0;
        n0 = rx_cnt;
        for (int i = 28; i < 32; i++) xfer({i[7:0], 24'habcdef});
        cmp_pkt(32'(rx_cnt), 32'(n0));
        cmp_bit(enabled, 1'b1);
        cmp_pkt(rsp_pkt, {`HPCG_OID_PARTID, `HPCG_PART_ID});
        xfer(32'h0);
        cmp_pkt(32'(bad_cnt), 32'h2);
        cmp_bit(enabled, 1'b1);
        xfer({8'h00, cs});
        cmp_pkt(32'(ok_cnt), 32'h3);
        $display("test special done");
    endtask
    task automatic t_send();
        logic [7:0] ids [5] = '{8'h00, 8'h01, 8'h57, 8'hff, 8'h60};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            tx_pkt <= {ids[i], 16'h1234, ids[i]};
            tx_valid <= 1'b1;
            @(negedge clk);
            while (tx_ready !== 1'b1) @(negedge clk);
            @(posedge clk);
            tx_valid <= 1'b0;
            xfer({8'h00, cs});
            if (i < 4) cmp_pkt(rsp_pkt, {ids[i], 16'h1234, ids[i]});
            else cmp_pkt(rsp_pkt, {`HPCG_OID_PARTID, `HPCG_PART_ID});
        end
        $display("test send done");
    endtask
    // bench-driven frame on the second link, nbits from bit 31 down
    task automatic bang(input logic [31:0] p, input int nbits, input logic sel);
        @(posedge clk);
        lk2.ss_n <= ~sel;
        repeat (8) @(posedge clk);
        for (int i = 31; i > 31 - nbits; i--) begin
            lk2.mosi <= p[i];
            repeat (4) @(posedge clk);
            lk2.sck <= 1'b1;
            repeat (4) @(posedge clk);
            lk2.sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        lk2.ss_n <= 1'b1;
        lk2.mosi <= ~lk2.mosi;
        repeat (8) @(negedge clk);
    endtask
    task automatic t_partial();
        bang(32'h02a5c3e1, 8, 1'b1);
        bang(32'h02a5c3e1, 32, 1'b0);
        cmp_pkt(32'(rx_cnt_b), 32'h0);
        bang(32'h02a5c3e1, 32, 1'b1);
        cmp_pkt(32'(rx_cnt_b), 32'h1);
        cmp_pkt(rx_pkt_b, 32'h02a5c3e1);
        $display("test partial done");
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        tx_valid = 1'b0;
        cmd_pkt = 32'h0;
        tx_pkt = 32'h0;
        lk2.sck = 1'b0;
        lk2.ss_n = 1'b1;
        lk2.mosi = 1'b0;
        cs = `HPCG_PART_ID;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(negedge clk);
        t_locked();
        t_decode();
        t_special();
        t_send();
        t_partial();
        wrap_up();
    end
endmodule
